/* hdl/pesu_core.sv */
// Power and energy scaling datapath with its coefficient registers.
`include "pesu_defines.svh"
module pesu_core
  import pesu_pkg::*;
#(
  parameter int RAW_W = 32,
  parameter int COEF_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic reg_busy,
  output logic [7:0] rd_byte,
  output logic rd_byte_valid,
  output logic rd_last,
  input wire logic [2:0][RAW_W-1:0] phase_real_power_raw,
  input wire logic [2:0][RAW_W-1:0] phase_quadrature_power_raw,
  input wire logic [2:0][RAW_W-1:0] phase_voltamp_power_raw,
  input wire logic [2:0][RAW_W-1:0] phase_real_power_fund_raw,
  input wire logic [2:0][RAW_W-1:0] phase_quadrature_power_fund_raw,
  input wire logic [2:0][RAW_W-1:0] phase_voltamp_power_fund_raw,
  input wire logic [2:0][RAW_W-1:0] real_energy_forward_acc,
  input wire logic [2:0][RAW_W-1:0] real_energy_reverse_acc,
  input wire logic [2:0][RAW_W-1:0] quad_energy_forward_acc,
  input wire logic [2:0][RAW_W-1:0] quad_energy_reverse_acc,
  input wire logic [2:0][RAW_W-1:0] voltamp_energy_acc,
  input wire logic [2:0][RAW_W-1:0] voltamp_energy_fund_acc,
  input wire logic [2:0][RAW_W-1:0] real_energy_fund_forward_acc,
  input wire logic [2:0][RAW_W-1:0] real_energy_fund_reverse_acc,
  input wire logic [2:0][RAW_W-1:0] quad_energy_fund_forward_acc,
  input wire logic [2:0][RAW_W-1:0] quad_energy_fund_reverse_acc
);
  // One term per phase carries a sign bit; three terms need two more.
  localparam int TERM_W = RAW_W + 1;
  localparam int SUM_W = RAW_W + 3;
  localparam int PROD_W = SUM_W + COEF_W + 1;

  // The 48-bit result field and the 16-bit register ports bound these.
  // Checked while the design is built, so a bad value never reaches a run.
  if (RAW_W < 8 || RAW_W > 32 || COEF_W != 16) begin : g_param_check
    $error("pesu_core: RAW_W must be 8..32 and COEF_W must be 16");
  end

  // Sequencer states: take, add phases, scale, send bytes.
  typedef enum logic [1:0] {S_IDLE, S_CALC, S_MUL, S_SEND} pesu_state_t;

  pesu_state_t state_reg; // Current sequencer state.
  pesu_kind_t kind_reg; // Quantity being served.
  logic [2:0] mask_reg; // Phases A, B, C taking part.
  logic [COEF_W-1:0] pwr_coef_reg; // Power scaling coefficient.
  logic [COEF_W-1:0] enr_coef_reg; // Energy scaling coefficient.
  logic signed [SUM_W-1:0] sum_reg; // Phase sum ahead of scaling.
  logic [63:0] res_reg; // Result frame, byte 0 leaves first.
  logic [2:0] cnt_reg; // Index of the byte being sent.
  logic [2:0] last_reg; // Index of the final byte.
  logic [7:0] rd_byte_reg; // Byte on the read port.
  logic rd_valid_reg; // Byte strobe.
  logic rd_last_reg; // Final byte strobe.
  logic signed [TERM_W-1:0] term [3]; // Per-phase operand.
  logic signed [SUM_W-1:0] sum_next; // Masked sum of the terms.
  logic [COEF_W-1:0] coef_sel; // Coefficient matching the quantity.
  logic signed [PROD_W-1:0] prod; // Scaled value.
  pesu_kind_t req_kind; // Decode of the address on the port.

  assign req_kind = pesu_decode(reg_addr);
  // A read is refused while a previous one is in flight.
  assign reg_busy = (state_reg != S_IDLE);
  assign rd_byte = rd_byte_reg;
  assign rd_byte_valid = rd_valid_reg;
  assign rd_last = rd_last_reg;

  // Coefficient registers; writes land at any time, even mid-read.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwr_coef_reg <= `PESU_COEF_RESET;
      enr_coef_reg <= `PESU_COEF_RESET;
    end else if (reg_wr) begin
      // Whole 16-bit writes; high byte and low byte move together.
      if (reg_addr == `PESU_ADDR_PWR_COEF) pwr_coef_reg <= reg_wdata;
      if (reg_addr == `PESU_ADDR_ENR_COEF) enr_coef_reg <= reg_wdata;
    end
  end

  // Picks each phase's operand for the quantity being served.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      unique case (kind_reg)
        PESU_K_P: term[p] = TERM_W'($signed(phase_real_power_raw[p]));
        PESU_K_Q: term[p] = TERM_W'($signed(phase_quadrature_power_raw[p]));
        PESU_K_S: term[p] = TERM_W'($signed(phase_voltamp_power_raw[p]));
        PESU_K_PF: term[p] = TERM_W'($signed(phase_real_power_fund_raw[p]));
        PESU_K_QF: term[p] = TERM_W'($signed(phase_quadrature_power_fund_raw[p]));
        PESU_K_SF: term[p] = TERM_W'($signed(phase_voltamp_power_fund_raw[p]));
        PESU_K_EP: term[p] = $signed({1'b0, real_energy_forward_acc[p]})
                            - $signed({1'b0, real_energy_reverse_acc[p]});
        PESU_K_EQ: term[p] = $signed({1'b0, quad_energy_forward_acc[p]})
                            - $signed({1'b0, quad_energy_reverse_acc[p]});
        PESU_K_ES: term[p] = $signed({1'b0, voltamp_energy_acc[p]});
        PESU_K_ESF: term[p] = $signed({1'b0, voltamp_energy_fund_acc[p]});
        PESU_K_EPF: term[p] = $signed({1'b0, real_energy_fund_forward_acc[p]})
                             - $signed({1'b0, real_energy_fund_reverse_acc[p]});
        PESU_K_EQF: term[p] = $signed({1'b0, quad_energy_fund_forward_acc[p]})
                             - $signed({1'b0, quad_energy_fund_reverse_acc[p]});
        default: term[p] = '0;
      endcase
    end
  end

  // Adds the selected phases; a total address selects all three.
  always_comb begin
    sum_next = '0;
    for (int p = 0; p < 3; p++) begin
      if (mask_reg[p]) sum_next = sum_next + SUM_W'(term[p]);
    end
  end

  // Energy quantities use the energy coefficient, the rest power.
  always_comb begin
    if (kind_reg inside {PESU_K_EP, PESU_K_EQ, PESU_K_ES,
                         PESU_K_EPF, PESU_K_EQF, PESU_K_ESF}) begin
      coef_sel = enr_coef_reg;
    end else begin
      coef_sel = pwr_coef_reg;
    end
  end

  assign prod = sum_reg * $signed({1'b0, coef_sel});

  // Request sequencer; raw inputs are sampled once, in the add cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      kind_reg <= PESU_K_NONE;
      mask_reg <= 3'h0;
      sum_reg <= '0;
      res_reg <= 64'h0;
      cnt_reg <= 3'h0;
      last_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (reg_rd) begin
            kind_reg <= req_kind;
            mask_reg <= reg_addr[2:0];
            state_reg <= S_CALC;
          end
        end
        S_CALC: begin
          sum_reg <= sum_next;
          state_reg <= S_MUL;
        end
        S_MUL: begin
          cnt_reg <= 3'h0;
          state_reg <= S_SEND;
          if (kind_reg == PESU_K_PCC) begin
            res_reg <= {48'h0, pwr_coef_reg};
            last_reg <= `PESU_COEF_BYTES;
          end else if (kind_reg == PESU_K_ECC) begin
            res_reg <= {48'h0, enr_coef_reg};
            last_reg <= `PESU_COEF_BYTES;
          end else begin
            res_reg <= {16'h0, prod[47:0]};
            last_reg <= `PESU_VIRT_BYTES;
          end
        end
        S_SEND: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == last_reg) state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Byte output; unmapped addresses return a frame of zero bytes.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_byte_reg <= 8'h0;
      rd_valid_reg <= 1'b0;
      rd_last_reg <= 1'b0;
    end else begin
      rd_valid_reg <= (state_reg == S_SEND);
      rd_last_reg <= (state_reg == S_SEND) && (cnt_reg == last_reg);
      rd_byte_reg <= (state_reg == S_SEND) ? res_reg[cnt_reg*8 +: 8] : 8'h0;
    end
  end

  a_pcc_reset_one: assert property (
    @(posedge ref_clk) $fell(rst) |-> pwr_coef_reg == 16'h0001)
    else $error("power coefficient not one after reset");
  a_ecc_reset_one: assert property (
    @(posedge ref_clk) $fell(rst) |-> enr_coef_reg == 16'h0001)
    else $error("energy coefficient not one after reset");
  a_phase_a_real: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_CALC && kind_reg == PESU_K_P && mask_reg == 3'b001
    |=> sum_reg == SUM_W'($signed($past(phase_real_power_raw[0]))))
    else $error("phase A real power source wrong");
  a_net_energy_b: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_CALC && kind_reg == PESU_K_EP && mask_reg == 3'b010
    |=> sum_reg == SUM_W'($signed({1'b0, $past(real_energy_forward_acc[1])})
                 - $signed({1'b0, $past(real_energy_reverse_acc[1])})))
    else $error("net real energy not forward minus reverse");
  a_total_three: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_CALC && kind_reg == PESU_K_ES && mask_reg == 3'b111
    |=> sum_reg == SUM_W'({1'b0, $past(voltamp_energy_acc[0])})
                 + SUM_W'({1'b0, $past(voltamp_energy_acc[1])})
                 + SUM_W'({1'b0, $past(voltamp_energy_acc[2])}))
    else $error("total is not the sum of three phases");
  // Both factors are widened first so the product keeps all 48 result bits.
  a_power_scaled: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_MUL && kind_reg == PESU_K_Q && !reg_wr
    |=> res_reg[47:0] == 48'($past(sum_reg)) * 48'($signed({1'b0, pwr_coef_reg})))
    else $error("power not scaled by power coefficient");
  a_energy_scaled: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_MUL && kind_reg == PESU_K_EP && !reg_wr
    |=> res_reg[47:0] == 48'($past(sum_reg)) * 48'($signed({1'b0, enr_coef_reg})))
    else $error("energy not scaled by energy coefficient");
  a_top_unused: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_SEND |-> res_reg[63:48] == 16'h0)
    else $error("top two result bytes not zero");
  a_first_byte_low: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_SEND && cnt_reg == 3'h0
    |=> rd_byte_valid && rd_byte == $past(res_reg[7:0]))
    else $error("first byte is not the least significant");
  a_eight_byte_len: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == S_IDLE && reg_rd && req_kind == PESU_K_EQ
    |-> ##4 rd_byte_valid [*8] ##0 rd_last)
    else $error("virtual read is not eight bytes");
endmodule

/* pkg/pesu_defines.svh */
// Constants shared by the power and energy scaling block.
// Notes on behaviour
// - Power coefficient 16 bits, resets to one.
// - Virtual power equals raw power times coefficient.
// - Phase power registers use matching phase sources.
// - Fundamental power registers scaled by power coefficient.
// - Energy coefficient 16 bits, resets to one.
// - Virtual energy equals accumulator times coefficient.
// - Net energy is forward minus reverse.
// - Apparent energy scales single accumulator, no direction.
// - Fundamental net energy uses fundamental accumulators.
// - Values computed on request, sent LSB first.
// - Results two's complement, sign in bit 47.
`ifndef PESU_DEFINES_SVH
`define PESU_DEFINES_SVH
`define PESU_ADDR_PWR_COEF 12'h018
`define PESU_ADDR_ENR_COEF 12'h01a
`define PESU_COEF_RESET 16'h0001
// Upper byte of each virtual address picks the quantity.
`define PESU_GRP_P 8'h80
`define PESU_GRP_Q 8'h81
`define PESU_GRP_S 8'h82
`define PESU_GRP_PF 8'h88
`define PESU_GRP_QF 8'h89
`define PESU_GRP_SF 8'h8a
`define PESU_GRP_EP 8'h8c
`define PESU_GRP_EQ 8'h8d
`define PESU_GRP_ES 8'h87
`define PESU_GRP_EPF 8'h8e
`define PESU_GRP_EQF 8'h8f
`define PESU_GRP_ESF 8'h8b
// Index of the final byte sent, for a virtual register and for a coefficient.
`define PESU_VIRT_BYTES 3'd7
`define PESU_COEF_BYTES 3'd1
`define PESU_SIGN_BIT 47
`endif

/* pkg/pesu_pkg.sv */
// Types and address decoding for the power and energy scaling block.
`include "pesu_defines.svh"
package pesu_pkg;
  // Quantity selected by a read address.
  typedef enum logic [3:0] {
    PESU_K_P, PESU_K_Q, PESU_K_S, PESU_K_PF, PESU_K_QF, PESU_K_SF,
    PESU_K_EP, PESU_K_EQ, PESU_K_ES, PESU_K_EPF, PESU_K_EQF, PESU_K_ESF,
    PESU_K_PCC, PESU_K_ECC, PESU_K_NONE
  } pesu_kind_t;

  // Maps a register address to the quantity it returns.
  function automatic pesu_kind_t pesu_decode(input logic [11:0] addr);
    logic [7:0] grp;
    logic [3:0] ph;
    grp = {4'h0, addr[11:8]} << 4 | {4'h0, addr[7:4]};
    ph = addr[3:0];
    pesu_decode = PESU_K_NONE;
    if (addr == `PESU_ADDR_PWR_COEF) pesu_decode = PESU_K_PCC;
    else if (addr == `PESU_ADDR_ENR_COEF) pesu_decode = PESU_K_ECC;
    else if (ph == 4'h1 || ph == 4'h2 || ph == 4'h4 || ph == 4'h7) begin
      unique case (grp)
        `PESU_GRP_P: pesu_decode = PESU_K_P;
        `PESU_GRP_Q: pesu_decode = PESU_K_Q;
        `PESU_GRP_S: pesu_decode = PESU_K_S;
        `PESU_GRP_PF: pesu_decode = PESU_K_PF;
        `PESU_GRP_QF: pesu_decode = PESU_K_QF;
        `PESU_GRP_SF: pesu_decode = PESU_K_SF;
        `PESU_GRP_EP: pesu_decode = PESU_K_EP;
        `PESU_GRP_EQ: pesu_decode = PESU_K_EQ;
        `PESU_GRP_ES: pesu_decode = PESU_K_ES;
        `PESU_GRP_EPF: pesu_decode = PESU_K_EPF;
        `PESU_GRP_EQF: pesu_decode = PESU_K_EQF;
        `PESU_GRP_ESF: pesu_decode = PESU_K_ESF;
        default: pesu_decode = PESU_K_NONE;
      endcase
    end
  endfunction
endpackage

/* verification/pesu_host_model.sv */
// Host master model driving the parallel register port of the scaling core.
module pesu_host_model (
  input wire logic ref_clk,
  input wire logic reg_busy,
  input wire logic [7:0] rd_byte,
  input wire logic rd_byte_valid,
  input wire logic rd_last,
  output logic [11:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  // The port idles with no request pending.
  initial begin
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end

  // One write; the idle cycle after it keeps the strobe from being set twice in a step.
  task automatic write_reg(input logic [11:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge ref_clk);
  endtask

  // Holds the request until taken, then scrambles the address so stale use shows.
  // bytes gathered low first.
  task automatic read_reg(input logic [11:0] a, output logic [63:0] v, output int lat,
      output int cnt);
    int k;
    v = 64'h0;
    lat = -1;
    cnt = 0;
    k = 0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (reg_busy !== 1'b0 && k < 20);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (k = 1; k <= 20; k++) begin
      @(posedge ref_clk);
      if (rd_byte_valid === 1'b1) begin
        if (cnt == 0) lat = k;
        if (cnt < 8) v[cnt*8 +: 8] = rd_byte;
        cnt++;
        if (rd_last === 1'b1) break;
      end
    end
  endtask
endmodule

/* verification/pesu_tb_top.sv */
// Self-checking bench for the power and energy scaling core.
`include "pesu_defines.svh"
module pesu_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic reg_rd;
  logic reg_busy;
  logic [7:0] rd_byte;
  logic rd_byte_valid;
  logic rd_last;
  // Raw sources in port order: six power inputs, then ten accumulators.
  logic [2:0][31:0] raw_q [16];
  int num_errors = 0;
  int check_count = 0;
  int cycle_cnt = 0;
  logic [15:0] pwr_coef;
  logic [15:0] enr_coef;
  localparam logic [7:0] GRP [12] = '{`PESU_GRP_P, `PESU_GRP_Q, `PESU_GRP_S, `PESU_GRP_PF,
    `PESU_GRP_QF, `PESU_GRP_SF, `PESU_GRP_EP, `PESU_GRP_EQ, `PESU_GRP_ES, `PESU_GRP_EPF,
    `PESU_GRP_EQF, `PESU_GRP_ESF};
  localparam logic [3:0] PH [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
  // Forward and reverse source per energy group; -1 means no reverse part.
  localparam int EF [6] = '{6, 8, 10, 12, 14, 11};
  localparam int ER [6] = '{7, 9, -1, 13, 15, -1};

  pesu_core uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_busy(reg_busy), .rd_byte(rd_byte),
    .rd_byte_valid(rd_byte_valid), .rd_last(rd_last),
    .phase_real_power_raw(raw_q[0]), .phase_quadrature_power_raw(raw_q[1]),
    .phase_voltamp_power_raw(raw_q[2]), .phase_real_power_fund_raw(raw_q[3]),
    .phase_quadrature_power_fund_raw(raw_q[4]), .phase_voltamp_power_fund_raw(raw_q[5]),
    .real_energy_forward_acc(raw_q[6]), .real_energy_reverse_acc(raw_q[7]),
    .quad_energy_forward_acc(raw_q[8]), .quad_energy_reverse_acc(raw_q[9]),
    .voltamp_energy_acc(raw_q[10]), .voltamp_energy_fund_acc(raw_q[11]),
    .real_energy_fund_forward_acc(raw_q[12]), .real_energy_fund_reverse_acc(raw_q[13]),
    .quad_energy_fund_forward_acc(raw_q[14]), .quad_energy_fund_reverse_acc(raw_q[15]));

  pesu_host_model host (.ref_clk(ref_clk), .reg_busy(reg_busy), .rd_byte(rd_byte),
    .rd_byte_valid(rd_byte_valid), .rd_last(rd_last), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  // Free-running 50 ns clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // A hung read must not stall the run; about 1200 cycles are expected.
  always @(posedge ref_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Single place where the run ends.
  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Expected answer: phase or three-phase sum, times coefficient, kept to 48 bits.
  function automatic logic [63:0] expect_val(input int g, input int p);
    logic signed [63:0] s;
    s = 64'sh0;
    for (int q = 0; q < 3; q++) begin
      if (p == 3 || p == q) begin
        if (g < 6) s += 64'(signed'(raw_q[g][q]));
        else begin
          s += 64'(raw_q[EF[g-6]][q]);
          if (ER[g-6] >= 0) s -= 64'(raw_q[ER[g-6]][q]);
        end
      end
    end
    s = s * 64'((g < 6) ? pwr_coef : enr_coef);
    return {16'h0000, s[47:0]};
  endfunction

  // Phase B power goes negative and reverse exceeds forward, so signs are exercised.
  task automatic load_raw();
    @(posedge ref_clk);
    for (int i = 0; i < 16; i++) begin
      for (int q = 0; q < 3; q++) begin
        if (q == 1 && i < 6) raw_q[i][q] <= -(32'(i * 41 + 7) * 32'h0001_3579);
        else raw_q[i][q] <= 32'(i * 41 + q * 13 + 7) * 32'h0001_3579;
      end
    end
  endtask

  // Reads both coefficient registers back.
  task automatic read_coefs(input logic [15:0] ep, input logic [15:0] ee);
    logic [63:0] v;
    int lat;
    int cnt;
    host.read_reg(`PESU_ADDR_PWR_COEF, v, lat, cnt);
    check(v, {48'h0, ep}, "power coefficient");
    check(64'(cnt), 64'd2, "coefficient byte count");
    host.read_reg(`PESU_ADDR_ENR_COEF, v, lat, cnt);
    check(v, {48'h0, ee}, "energy coefficient");
    check(64'(cnt), 64'd2, "energy coefficient byte count");
  endtask

  // Host picks coefficients above one thousand; a stray write must change nothing.
  task automatic t_write();
    pwr_coef = 16'h1234;
    enr_coef = 16'h0bb8;
    host.write_reg(`PESU_ADDR_PWR_COEF, pwr_coef);
    host.write_reg(`PESU_ADDR_ENR_COEF, enr_coef);
    host.write_reg(12'h01c, 16'hffff);
    read_coefs(pwr_coef, enr_coef);
  endtask

  // Every phase and total of groups g0..g1, read back to back.
  task automatic t_sweep(input int g0, input int g1);
    logic [63:0] v;
    int lat;
    int cnt;
    for (int g = g0; g <= g1; g++) begin
      for (int p = 0; p < 4; p++) begin
        host.read_reg({GRP[g], PH[p]}, v, lat, cnt);
        check(v, expect_val(g, p), "virtual value");
        check(64'(cnt), 64'd8, "virtual byte count");
        check(64'(lat), 64'd4, "first byte delay");
      end
    end
  endtask

  // An unmapped phase nibble answers with eight zero bytes; busy is high one edge after a request is taken and low after the final byte.
  task automatic t_unmapped();
    logic [63:0] v;
    int lat;
    int cnt;
    host.read_reg({`PESU_GRP_P, 4'h3}, v, lat, cnt);
    check(v, 64'h0, "unmapped value");
    check(64'(cnt), 64'd8, "unmapped byte count");
    check(64'(reg_busy), 64'd0, "busy after final byte");
    // A bare request: taken at the next edge, busy seen one edge later.
    host.reg_addr <= {`PESU_GRP_S, 4'h7};
    host.reg_rd <= 1'b1;
    @(posedge ref_clk);
    host.reg_rd <= 1'b0;
    @(posedge ref_clk);
    check(64'(reg_busy), 64'd1, "busy during frame");
    // Let the frame drain so the run ends with the port idle.
    repeat (11) @(posedge ref_clk);
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    foreach (raw_q[i]) raw_q[i] = '0;
    pwr_coef = 16'h0001;
    enr_coef = 16'h0001;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    read_coefs(16'h0001, 16'h0001);
    load_raw();
    t_sweep(0, 11);
    t_write();
    t_sweep(0, 5);
    t_sweep(6, 11);
    t_unmapped();
    end_of_test();
  end
endmodule
